// file: rtl/sdl_consts.svh
/*
 Constants of the strap default latch: register byte offsets,
 field positions and strap default levels.
 Assumes a 32-bit APB slave with word-aligned registers.
*/
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH

// ==========================================================
// Register byte offsets.
`define SDL_A_MAC_TX    8'h00
`define SDL_A_PHY_LP    8'h04
`define SDL_A_VPHY_SPC  8'h08
`define SDL_A_P0_FLOW   8'h0c
`define SDL_A_VPHY_LP   8'h10
`define SDL_A_VPHY_ADV  8'h14
`define SDL_A_STATUS    8'h18

// ==========================================================
// Field positions.
`define SDL_B_PHY_EN    0
`define SDL_B_PHY_CAP   1
`define SDL_B_PHY_ADV   2
`define SDL_B_BP        0
`define SDL_B_TXFC      1
`define SDL_B_RXFC      2
`define SDL_B_PAUSE     0
`define SDL_B_ASYM      1

// ==========================================================
// Loader selectors for the soft straps.
`define SDL_L_LP        3'h0
`define SDL_L_HB        3'h1
`define SDL_L_BP        3'h2
`define SDL_L_FDFC      3'h3
`define SDL_L_MFC       3'h4

// ==========================================================
// Soft strap default levels.
`define SDL_DEF_HB      1'b0
`define SDL_DEF_BP      1'b1
`define SDL_DEF_FDFC    1'b1
`define SDL_DEF_MFC     1'b0

`endif

// file: rtl/sdl_pkg.sv
/*
 Types of the strap default latch.
 Assumes the constants header is included by users.
*/
`default_nettype none
package sdl_pkg;
	// Reset sequencing: capture pins, load defaults, run.
	typedef enum logic [1:0] {
		SDL_CAPTURE,
		SDL_LOAD,
		SDL_RUN
	} sdl_state_e;
	typedef logic [31:0] sdl_word_t;
endpackage : sdl_pkg
`default_nettype wire

// file: rtl/sdl_strap_latch.sv
/*
 Strap capture and register default loader with an APB slave.
 Assumes strap pins and resets are synchronous to clock.
*/
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sdl_consts.svh"

module sdl_strap_latch
	import sdl_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        pin_reset_n,
	input  wire logic        soft_reset,
	input  wire logic        low_power_enable_pin,
	input  wire logic        prom_size_pin,
	input  wire logic        phy_fiber_mode,
	input  wire logic        loader_we,
	input  wire logic [2:0]  loader_sel,
	input  wire logic        loader_val,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             prom_large_range,
	output logic             straps_ready,
	output logic             mac_low_power_enable_bit,
	output logic             port0_backpressure_enable_bit,
	output logic             port0_tx_flow_enable_bit,
	output logic             port0_rx_flow_enable_bit,
	output logic             heartbeat_disable_bit
);

	// ==========================================================
	// Helpers.
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	sdl_state_e state;
	logic       hard_prom_size;
	logic       port2_low_power_enable_strap;
	logic       port0_heartbeat_disable_strap;
	logic       port0_backpressure_strap;
	logic       port0_full_duplex_flow_strap;
	logic       port0_manual_flow_strap;
	logic       lp_overridden;
	logic [2:0] phy_lp;
	logic [1:0] vphy_partner;
	logic [1:0] vphy_advert;
	logic       lp_default;
	logic       wr;
	logic       rd;
	logic       mapped;
	sdl_word_t  next_rdata;

	// ==========================================================
	// Sequencer: the pin reset holds capture; soft reset
	// only reloads defaults and never re-enters capture.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= SDL_CAPTURE;
		end else if (!pin_reset_n) begin
			state <= SDL_CAPTURE;
		end else begin
			case (state)
				SDL_CAPTURE: state <= SDL_LOAD;
				SDL_LOAD:    state <= SDL_RUN;
				default: begin
					if (soft_reset) begin
						state <= SDL_LOAD;
					end
				end
			endcase
		end
	end

	// Hard strap: sampled on the edge that leaves capture, held
	// afterwards; the loader has no path into it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hard_prom_size <= 1'b0;
		end else if (state == SDL_CAPTURE && pin_reset_n) begin
			hard_prom_size <= prom_size_pin;
		end
	end

	// The size range is a direct configuration value.
	assign prom_large_range = hard_prom_size;
	assign straps_ready     = (state == SDL_RUN);

	// ==========================================================
	// Soft straps: defaults at capture, the low-power one from
	// its pin; the loader may replace any soft strap later.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port2_low_power_enable_strap  <= 1'b0;
			lp_overridden                 <= 1'b0;
			port0_heartbeat_disable_strap <= `SDL_DEF_HB;
			port0_backpressure_strap      <= `SDL_DEF_BP;
			port0_full_duplex_flow_strap  <= `SDL_DEF_FDFC;
			port0_manual_flow_strap       <= `SDL_DEF_MFC;
		end else if (state == SDL_CAPTURE) begin
			port2_low_power_enable_strap  <= low_power_enable_pin;
			lp_overridden                 <= 1'b0;
			port0_heartbeat_disable_strap <= `SDL_DEF_HB;
			port0_backpressure_strap      <= `SDL_DEF_BP;
			port0_full_duplex_flow_strap  <= `SDL_DEF_FDFC;
			port0_manual_flow_strap       <= `SDL_DEF_MFC;
		end else if (loader_we) begin
			// Selectors outside the soft set are ignored.
			if (loader_sel == `SDL_L_LP) begin
				port2_low_power_enable_strap <= loader_val;
				lp_overridden                <= 1'b1;
			end else if (loader_sel == `SDL_L_HB) begin
				port0_heartbeat_disable_strap <= loader_val;
			end else if (loader_sel == `SDL_L_BP) begin
				port0_backpressure_strap <= loader_val;
			end else if (loader_sel == `SDL_L_FDFC) begin
				port0_full_duplex_flow_strap <= loader_val;
			end else if (loader_sel == `SDL_L_MFC) begin
				port0_manual_flow_strap <= loader_val;
			end
		end
	end

	// Fiber links never negotiate low power, so it stays off.
	assign lp_default = port2_low_power_enable_strap
		& ~phy_fiber_mode;

	// ==========================================================
	// APB decode. Zero wait states: data is fetched in setup.
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	always_comb begin
		mapped = hit(paddr, `SDL_A_MAC_TX)
			|| hit(paddr, `SDL_A_PHY_LP)
			|| hit(paddr, `SDL_A_VPHY_SPC)
			|| hit(paddr, `SDL_A_P0_FLOW)
			|| hit(paddr, `SDL_A_VPHY_LP)
			|| hit(paddr, `SDL_A_VPHY_ADV)
			|| hit(paddr, `SDL_A_STATUS);
	end
	assign pslverr = psel && penable && !mapped;

	// ==========================================================
	// Port 2 MAC low-power enable.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mac_low_power_enable_bit <= 1'b0;
		end else if (state == SDL_LOAD) begin
			mac_low_power_enable_bit <= lp_default;
		end else if (wr && hit(paddr, `SDL_A_MAC_TX)) begin
			mac_low_power_enable_bit <= pwdata[0];
		end
	end

	// PHY B low-power enable, capability and advertisement.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phy_lp <= 3'h0;
		end else if (state == SDL_LOAD) begin
			phy_lp <= {3{lp_default}};
		end else if (wr && hit(paddr, `SDL_A_PHY_LP)) begin
			phy_lp <= pwdata[2:0];
		end
	end

	// Virtual PHY heartbeat disable.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			heartbeat_disable_bit <= `SDL_DEF_HB;
		end else if (state == SDL_LOAD) begin
			heartbeat_disable_bit <= port0_heartbeat_disable_strap;
		end else if (wr && hit(paddr, `SDL_A_VPHY_SPC)) begin
			heartbeat_disable_bit <= pwdata[0];
		end
	end

	// Port 0 backpressure and full-duplex flow enables.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port0_backpressure_enable_bit <= `SDL_DEF_BP;
			port0_tx_flow_enable_bit      <= `SDL_DEF_FDFC;
			port0_rx_flow_enable_bit      <= `SDL_DEF_FDFC;
		end else if (state == SDL_LOAD) begin
			port0_backpressure_enable_bit <= port0_backpressure_strap;
			port0_tx_flow_enable_bit      <= port0_full_duplex_flow_strap;
			port0_rx_flow_enable_bit      <= port0_full_duplex_flow_strap;
		end else if (wr && hit(paddr, `SDL_A_P0_FLOW)) begin
			port0_backpressure_enable_bit <= pwdata[`SDL_B_BP];
			port0_tx_flow_enable_bit      <= pwdata[`SDL_B_TXFC];
			port0_rx_flow_enable_bit      <= pwdata[`SDL_B_RXFC];
		end
	end

	// Virtual PHY partner ability and advertised pause bits.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vphy_partner <= {2{`SDL_DEF_FDFC}};
			vphy_advert  <= {2{`SDL_DEF_MFC}};
		end else if (state == SDL_LOAD) begin
			vphy_partner <= {2{port0_full_duplex_flow_strap}};
			vphy_advert  <= {2{port0_manual_flow_strap}};
		end else if (wr) begin
			if (hit(paddr, `SDL_A_VPHY_LP)) begin
				vphy_partner <= pwdata[1:0];
			end else if (hit(paddr, `SDL_A_VPHY_ADV)) begin
				vphy_advert <= pwdata[1:0];
			end
		end
	end

	// ==========================================================
	// Read mux; the status word shows latched straps and state.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit(paddr, `SDL_A_MAC_TX)) begin
			next_rdata[0] = mac_low_power_enable_bit;
		end else if (hit(paddr, `SDL_A_PHY_LP)) begin
			next_rdata[2:0] = phy_lp;
		end else if (hit(paddr, `SDL_A_VPHY_SPC)) begin
			next_rdata[0] = heartbeat_disable_bit;
		end else if (hit(paddr, `SDL_A_P0_FLOW)) begin
			next_rdata[2:0] = {port0_rx_flow_enable_bit,
				port0_tx_flow_enable_bit,
				port0_backpressure_enable_bit};
		end else if (hit(paddr, `SDL_A_VPHY_LP)) begin
			next_rdata[1:0] = vphy_partner;
		end else if (hit(paddr, `SDL_A_VPHY_ADV)) begin
			next_rdata[1:0] = vphy_advert;
		end else if (hit(paddr, `SDL_A_STATUS)) begin
			next_rdata[8:0] = {lp_overridden, phy_fiber_mode,
				straps_ready, port0_manual_flow_strap,
				port0_full_duplex_flow_strap,
				port0_backpressure_strap,
				port0_heartbeat_disable_strap,
				port2_low_power_enable_strap, hard_prom_size};
		end
	end

	// Read data is registered in the setup cycle.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (rd) begin
			prdata <= next_rdata;
		end
	end

	// ==========================================================
	// Assertions.
	property p_fiber_off;
		@(posedge clock) disable iff (rst)
		(state == SDL_LOAD && phy_fiber_mode)
			|=> !mac_low_power_enable_bit && phy_lp == 3'h0;
	endproperty
	a_fiber_off: assert property (p_fiber_off)
		else $error("fiber mode left low power on");

	property p_mac_lp;
		@(posedge clock) disable iff (rst)
		state == SDL_LOAD |=> mac_low_power_enable_bit
			== ($past(port2_low_power_enable_strap)
			& ~$past(phy_fiber_mode));
	endproperty
	a_mac_lp: assert property (p_mac_lp)
		else $error("mac low power default wrong");

	property p_phy_lp;
		@(posedge clock) disable iff (rst)
		state == SDL_LOAD |=> phy_lp == {3{mac_low_power_enable_bit}};
	endproperty
	a_phy_lp: assert property (p_phy_lp)
		else $error("phy low power defaults differ");

	property p_heartbeat;
		@(posedge clock) disable iff (rst)
		(state == SDL_CAPTURE && pin_reset_n) |=> ##1
			heartbeat_disable_bit == `SDL_DEF_HB;
	endproperty
	a_heartbeat: assert property (p_heartbeat)
		else $error("heartbeat default not zero");

	property p_flow;
		@(posedge clock) disable iff (rst)
		state == SDL_LOAD |=>
			port0_backpressure_enable_bit == $past(port0_backpressure_strap)
			&& port0_tx_flow_enable_bit == $past(port0_full_duplex_flow_strap)
			&& port0_rx_flow_enable_bit == port0_tx_flow_enable_bit;
	endproperty
	a_flow: assert property (p_flow)
		else $error("port 0 flow defaults wrong");

	property p_pause;
		@(posedge clock) disable iff (rst)
		state == SDL_LOAD |=>
			vphy_partner == {2{$past(port0_full_duplex_flow_strap)}}
			&& vphy_advert == {2{$past(port0_manual_flow_strap)}};
	endproperty
	a_pause: assert property (p_pause)
		else $error("virtual phy pause defaults wrong");

	property p_hard_hold;
		@(posedge clock) disable iff (rst)
		(state != SDL_CAPTURE) |=> $stable(hard_prom_size);
	endproperty
	a_hard_hold: assert property (p_hard_hold)
		else $error("hard strap changed outside capture");

	property p_range;
		@(posedge clock) disable iff (rst)
		(state == SDL_CAPTURE && pin_reset_n)
			|=> prom_large_range == $past(prom_size_pin);
	endproperty
	a_range: assert property (p_range)
		else $error("prom range not from pin");

	property p_soft_reset;
		@(posedge clock) disable iff (rst)
		(state == SDL_RUN && soft_reset && pin_reset_n)
			|=> state == SDL_LOAD ##1 state == SDL_RUN;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset re-entered capture");

	c_soft: cover property (@(posedge clock) disable iff (rst)
		state == SDL_RUN && soft_reset);
	c_fiber: cover property (@(posedge clock) disable iff (rst)
		state == SDL_LOAD && phy_fiber_mode);
	c_loader: cover property (@(posedge clock) disable iff (rst)
		loader_we && state == SDL_RUN);

endmodule : sdl_strap_latch
`default_nettype wire

// file: test/sdl_board_model.sv
/*
 Board side of the strap latch: strap pin levels, the reset pin
 and the prom loader write port.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module sdl_board_model (
	input  wire logic       clock,
	output logic            pin_reset_n,
	output logic            low_power_enable_pin,
	output logic            prom_size_pin,
	output logic            phy_fiber_mode,
	output logic            loader_we,
	output logic [2:0]      loader_sel,
	output logic            loader_val
);
	// ==========================================================
	// Idle levels: reset pin released, straps at board defaults.
	initial begin
		pin_reset_n = 1'b1;
		low_power_enable_pin = 1'b1;
		prom_size_pin = 1'b1;
		phy_fiber_mode = 1'b0;
		loader_we = 1'b0;
		loader_sel = 3'h0;
		loader_val = 1'b0;
	end

	// Board strap levels; only the next qualifying reset should see them.
	task automatic set_pins(input logic lp, input logic size, input logic fiber);
		@(posedge clock);
		low_power_enable_pin <= lp;
		prom_size_pin <= size;
		phy_fiber_mode <= fiber;
	endtask : set_pins

	// Pin reset held low for a few cycles, as a supervisor would.
	task automatic pin_reset();
		@(posedge clock);
		pin_reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		pin_reset_n <= 1'b1;
	endtask : pin_reset

	// One loader write; the lines are scrambled afterwards so that a
	// late sample of a released bus never looks like valid data.
	task automatic load(input logic [2:0] sel, input logic val);
		@(posedge clock);
		loader_we <= 1'b1;
		loader_sel <= sel;
		loader_val <= val;
		@(posedge clock);
		loader_we <= 1'b0;
		loader_sel <= ~sel;
		loader_val <= ~val;
	endtask : load
endmodule : sdl_board_model

`default_nettype wire

// file: test/tb_top.sv
/*
 Self-checking bench of the strap latch: APB read and write tasks,
 reset sequences and loader traffic with expected register values.
 Assumes the design answers every APB access with pready in time.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdl_consts.svh"

module tb_top;
	logic        clock, rst, soft_reset, psel, penable, pwrite, pready, pslverr;
	logic        pin_reset_n, lp_pin, size_pin, fiber, ld_we, ld_val;
	logic [2:0]  ld_sel;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        err, prom_large, ready, mac_lp, bp, txfc, rxfc, hb;
	int          failures, check_count;

	sdl_board_model board (.clock(clock), .pin_reset_n(pin_reset_n),
		.low_power_enable_pin(lp_pin), .prom_size_pin(size_pin), .phy_fiber_mode(fiber),
		.loader_we(ld_we), .loader_sel(ld_sel), .loader_val(ld_val));

	sdl_strap_latch dut (.clock(clock), .rst(rst), .pin_reset_n(pin_reset_n),
		.soft_reset(soft_reset), .low_power_enable_pin(lp_pin), .prom_size_pin(size_pin),
		.phy_fiber_mode(fiber), .loader_we(ld_we), .loader_sel(ld_sel), .loader_val(ld_val),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .prom_large_range(prom_large),
		.straps_ready(ready), .mac_low_power_enable_bit(mac_lp),
		.port0_backpressure_enable_bit(bp), .port0_tx_flow_enable_bit(txfc),
		.port0_rx_flow_enable_bit(rxfc), .heartbeat_disable_bit(hb));

	// ==========================================================
	// Clock and verdict.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic close_out();
		if (failures == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// ==========================================================
	// APB master; an idle cycle first keeps back-to-back calls clean.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Six word registers, three bits each, packed lowest offset first.
	task automatic chk_regs(input logic [17:0] e);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			cmp("register", {29'h0, e[3*i+:3]}, rd);
		end
	endtask : chk_regs

	task automatic chk_pins(input logic [5:0] e);
		cmp("outputs", {26'h0, e}, {26'h0, prom_large, mac_lp, bp, txfc, rxfc, hb});
	endtask : chk_pins

	// Ready is low until the load stage finishes, so a bounded poll suffices.
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		cmp("straps_ready", 32'h1, {31'h0, ready});
	endtask : wait_ready

	// ==========================================================
	// Watchdog; the sequence needs well under a thousand cycles.
	initial begin
		#50000;
		failures++;
		close_out();
	end

	// ==========================================================
	// Main sequence.
	initial begin
		failures = 0;
		check_count = 0;
		rst = 1'b1;
		soft_reset = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		wait_ready();
		chk_regs({3'h0, 3'h3, 3'h7, 3'h0, 3'h7, 3'h1});
		chk_pins(6'h3e);
		// Loader overrides soft straps; the size pin moves but must not relatch.
		board.set_pins(1'b1, 1'b0, 1'b0);
		board.load(`SDL_L_LP, 1'b0);
		board.load(`SDL_L_HB, 1'b1);
		board.load(`SDL_L_BP, 1'b0);
		board.load(`SDL_L_FDFC, 1'b0);
		board.load(`SDL_L_MFC, 1'b1);
		for (int s = 5; s < 8; s++) begin
			board.load(3'(s), 1'b1);
		end
		@(posedge clock);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		repeat (3) @(posedge clock);
		wait_ready();
		chk_regs({3'h3, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0});
		chk_pins(6'h21);
		// Status shows the loaded soft straps and the untouched hard strap.
		apb(1'b0, `SDL_A_STATUS, 32'h0);
		cmp("status", 32'h0000_0165, rd);
		// Pin reset relatches the hard strap; fiber mode gates low power.
		board.set_pins(1'b1, 1'b0, 1'b1);
		board.pin_reset();
		wait_ready();
		chk_regs({3'h0, 3'h3, 3'h7, 3'h0, 3'h0, 3'h0});
		chk_pins(6'h0e);
		apb(1'b0, `SDL_A_STATUS, 32'h0);
		cmp("status", 32'h0000_00da, rd);
		// Software write over a strapped default, then an unmapped read.
		apb(1'b1, `SDL_A_P0_FLOW, 32'h0);
		apb(1'b0, `SDL_A_P0_FLOW, 32'h0);
		cmp("flow reg", 32'h0, rd);
		cmp("flow err", 32'h0, {31'h0, err});
		chk_pins(6'h00);
		apb(1'b0, 8'h1c, 32'h0);
		cmp("unmapped data", 32'h0, rd);
		cmp("unmapped err", 32'h1, {31'h0, err});
		close_out();
	end
endmodule : tb_top

`default_nettype wire
